// ===== twl_defines.svh
// Offsets, field positions, reset values and timing counts for the loader.
// Assumes a 20 MHz core clock and an 11-bit byte address into the store.
`ifndef TWL_DEFINES_SVH
`define TWL_DEFINES_SVH

`define TWL_WS_BYTES 7'd76
`define TWL_TABLE_BYTES 7'd70
`define TWL_LAST_WS_BYTE 7'd75
`define TWL_LAST_SET 5'd24
`define TWL_WIN_BASE 11'd1900
`define TWL_WIN_LAST_BYTE 2'd2

`define TWL_IDX_GATE 7'd70
`define TWL_IDX_VSH1 7'd71
`define TWL_IDX_VSH2 7'd72
`define TWL_IDX_VSL 7'd73
`define TWL_IDX_DUMMY 7'd74
`define TWL_IDX_WIDTH 7'd75

`define TWL_CMD_WS 8'h32
`define TWL_CMD_GATE 8'h03
`define TWL_CMD_SRC 8'h04
`define TWL_CMD_DUMMY 8'h3a
`define TWL_CMD_WIDTH 8'h3b

`define TWL_RST_GATE 8'h00
`define TWL_RST_VSH1 8'h41
`define TWL_RST_VSH2 8'ha8
`define TWL_RST_VSL 8'h32
`define TWL_RST_DUMMY 8'h00
`define TWL_RST_WIDTH 8'h00
`define TWL_RST_TEMP 12'h000

`define TWL_SENSOR_ADDR 7'h48

`define TWL_CLK_MHZ 20
`define TWL_SCL_QUARTER_NS 2500
`define TWL_SCL_QUARTER_CYC ((`TWL_SCL_QUARTER_NS * `TWL_CLK_MHZ + 999) / 1000)

`define TWL_BIT_ADDR_LAST 5'd7
`define TWL_BIT_ACK 5'd8
`define TWL_BIT_B1_FIRST 5'd9
`define TWL_BIT_B1_LAST 5'd16
`define TWL_BIT_MACK 5'd17
`define TWL_BIT_B2_FIRST 5'd18
`define TWL_BIT_B2_LAST 5'd25
`define TWL_BIT_LAST 5'd26

`endif

// ===== twl_pkg.sv
// Types shared by the waveform loader and its window comparator.
// Assumes twl_defines.svh supplies all numeric constants.
package twl_pkg;

    typedef enum logic [5:0] {
        L_IDLE = 6'h01,
        L_TEMP = 6'h02,
        L_SCAN = 6'h04,
        L_COPY = 6'h08
    } twl_load_st_t;

    typedef enum logic [3:0] {
        I_IDLE = 4'h1,
        I_START = 4'h2,
        I_BIT = 4'h4,
        I_STOP = 4'h8
    } twl_i2c_st_t;

    typedef struct packed {
        logic [7:0] gate_level;
        logic [7:0] vsh1;
        logic [7:0] vsh2;
        logic [7:0] vsl;
        logic [7:0] dummy_line;
        logic [7:0] gate_width;
    } twl_volt_t;

    typedef struct packed {
        logic [11:0] high;
        logic [11:0] low;
    } twl_win_t;

endpackage

// ===== twl_win_match.sv
// Signed temperature window test for one temperature_window.
// Assumes both limits and the reading are 12-bit two's complement.
`timescale 1ns/1ps
module twl_win_match
    import twl_pkg::*;
(
    input wire logic [11:0] temp,
    input wire twl_win_t win,
    output logic hit
);
    // Low limit exclusive, high limit inclusive
    always_comb
    begin
        hit = ($signed(temp) > $signed(win.low)) && ($signed(temp) <= $signed(win.high));
    end
endmodule

// ===== twl_loader.sv
// Temperature-driven waveform loader: host writes, sensor read, window scan, copy.
// Assumes a store read port on clk answering each request with one ack pulse.
// What this block does
// - Command 0x32 data fills bytes 0 to 69
// - Command 0x03 data sets byte 70
// - Command 0x04 data sets bytes 71 to 73
// - Command 0x3A data sets byte 74
// - Command 0x3B data sets byte 75
// - Table loads from host or from store
// - Store holds 25 sets plus 25 windows
// - Set m loads when low < temp <= high
// - Set m starts at byte m times 76
// - Windows: three bytes each from byte 1900
// - Scan windows 0 to 24, last match wins
// - No ordering assumed among window limits
// - 560-bit volatile waveform table register
// - 12-bit temperature register for comparison
// - Selection pointer keeps chosen set index
// - Single open-drain two-wire master to sensor
// - Temperature is signed, sixteenth degree units
`timescale 1ns/1ps
`include "twl_defines.svh"
module twl_loader
    import twl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_is_data,
    input wire logic [7:0] cmd_byte,
    input wire logic load_start,
    output logic nvm_req,
    output logic [10:0] nvm_addr,
    input wire logic nvm_ack,
    input wire logic [7:0] nvm_rdata,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    output logic [559:0] waveform_table_register,
    output twl_volt_t volt_setting,
    output logic [11:0] temperature,
    output logic [4:0] selection_pointer,
    output logic busy,
    output logic sensor_error
);
    twl_load_st_t lst_q;
    twl_i2c_st_t ist_q;
    logic [559:0] table_q;
    twl_volt_t volt_q;
    logic [11:0] temp_q;
    logic [4:0] sel_q;
    logic busy_q;
    logic err_q;
    logic [7:0] cmd_q;
    logic [6:0] hcnt_q;
    logic host_ok;
    logic [6:0] host_idx;
    logic wr_en;
    logic [6:0] wr_idx;
    logic [7:0] wr_data;
    logic req_q;
    logic [10:0] addr_q;
    logic [4:0] wcnt_q;
    logic [1:0] kcnt_q;
    logic [6:0] ccnt_q;
    logic [7:0] wb0_q;
    logic [7:0] wb1_q;
    logic [4:0] cand_q;
    logic found_q;
    twl_win_t win;
    logic hit;
    logic fin_found;
    logic [4:0] fin_idx;
    logic sda_m_q;
    logic sda_s_q;
    logic scl_m_q;
    logic scl_s_q;
    logic [7:0] qcnt_q;
    logic [1:0] qph_q;
    logic [4:0] bit_q;
    logic [15:0] sh_q;
    logic nack_q;
    logic i2c_done_q;
    logic sda_oe_n_q;
    logic scl_oe_n_q;
    logic stall;
    logic tick;
    logic [7:0] addr_byte;

    assign waveform_table_register = table_q;
    assign volt_setting = volt_q;
    assign temperature = temp_q;
    assign selection_pointer = sel_q;
    assign busy = busy_q;
    assign sensor_error = err_q;
    assign nvm_req = req_q;
    assign nvm_addr = addr_q;
    assign sda_oe_n = sda_oe_n_q;
    assign scl_oe_n = scl_oe_n_q;
    // Open-drain pins only ever pull low; the level comes from pull-ups
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;

    // Host command tracking; data bytes count up after each command byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q <= 8'h00;
            hcnt_q <= 7'h00;
        end
        else if (cmd_valid && !cmd_is_data)
        begin
            cmd_q <= cmd_byte;
            hcnt_q <= 7'h00;
        end
        else if (cmd_valid && hcnt_q != 7'h7f)
        begin
            hcnt_q <= hcnt_q + 7'h01;
        end
    end

    // Map a host data byte to its waveform setting byte
    always_comb
    begin
        host_ok = 1'b0;
        host_idx = 7'h00;
        case (cmd_q)
            `TWL_CMD_WS:
            begin
                host_ok = hcnt_q < `TWL_TABLE_BYTES;
                host_idx = hcnt_q;
            end
            `TWL_CMD_GATE:
            begin
                host_ok = hcnt_q == 7'h00;
                host_idx = `TWL_IDX_GATE;
            end
            `TWL_CMD_SRC:
            begin
                host_ok = hcnt_q < 7'h03;
                host_idx = `TWL_IDX_VSH1 + hcnt_q;
            end
            `TWL_CMD_DUMMY:
            begin
                host_ok = hcnt_q == 7'h00;
                host_idx = `TWL_IDX_DUMMY;
            end
            `TWL_CMD_WIDTH:
            begin
                host_ok = hcnt_q == 7'h00;
                host_idx = `TWL_IDX_WIDTH;
            end
            default:
            begin
                host_ok = 1'b0;
                host_idx = 7'h00;
            end
        endcase
    end

    // One write port shared by host and store copy; host is locked out while busy
    always_comb
    begin
        wr_en = 1'b0;
        wr_idx = 7'h00;
        wr_data = 8'h00;
        if (lst_q == L_COPY && nvm_ack)
        begin
            wr_en = 1'b1;
            wr_idx = ccnt_q;
            wr_data = nvm_rdata;
        end
        else if (!busy_q && cmd_valid && cmd_is_data && host_ok)
        begin
            wr_en = 1'b1;
            wr_idx = host_idx;
            wr_data = cmd_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            table_q <= 560'h0;
        end
        else if (wr_en && wr_idx < `TWL_TABLE_BYTES)
        begin
            table_q[wr_idx * 8 +: 8] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            volt_q <= {`TWL_RST_GATE, `TWL_RST_VSH1, `TWL_RST_VSH2, `TWL_RST_VSL, `TWL_RST_DUMMY, `TWL_RST_WIDTH};
        end
        else if (wr_en)
        begin
            case (wr_idx)
                `TWL_IDX_GATE: volt_q.gate_level <= wr_data;
                `TWL_IDX_VSH1: volt_q.vsh1 <= wr_data;
                `TWL_IDX_VSH2: volt_q.vsh2 <= wr_data;
                `TWL_IDX_VSL: volt_q.vsl <= wr_data;
                `TWL_IDX_DUMMY: volt_q.dummy_line <= wr_data;
                `TWL_IDX_WIDTH: volt_q.gate_width <= wr_data;
                default: volt_q <= volt_q;
            endcase
        end
    end

    // Window assembled from the two held bytes and the byte now arriving
    always_comb
    begin
        win.low = {wb1_q[3:0], wb0_q};
        win.high = {nvm_rdata, wb1_q[7:4]};
    end

    twl_win_match u_match (
        .temp(temp_q),
        .win(win),
        .hit(hit)
    );

    // Each window is judged alone, so unsorted or overlapping limits are fine
    assign fin_found = found_q || hit;
    assign fin_idx = hit ? wcnt_q : cand_q;

    // Loader sequence: sensor read, 25-window scan, then 76-byte copy
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lst_q <= L_IDLE;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            addr_q <= 11'h000;
            wcnt_q <= 5'h00;
            kcnt_q <= 2'h0;
            ccnt_q <= 7'h00;
            wb0_q <= 8'h00;
            wb1_q <= 8'h00;
            cand_q <= 5'h00;
            found_q <= 1'b0;
            sel_q <= 5'h00;
        end
        else
        begin
            case (lst_q)
                L_IDLE:
                begin
                    if (load_start)
                    begin
                        lst_q <= L_TEMP;
                        busy_q <= 1'b1;
                    end
                end
                L_TEMP:
                begin
                    if (i2c_done_q)
                    begin
                        err_q <= nack_q;
                        lst_q <= nack_q ? L_IDLE : L_SCAN;
                        busy_q <= !nack_q;
                        addr_q <= `TWL_WIN_BASE;
                        wcnt_q <= 5'h00;
                        kcnt_q <= 2'h0;
                        found_q <= 1'b0;
                    end
                end
                L_SCAN:
                begin
                    if (nvm_ack)
                    begin
                        addr_q <= addr_q + 11'h001;
                        kcnt_q <= (kcnt_q == `TWL_WIN_LAST_BYTE) ? 2'h0 : kcnt_q + 2'h1;
                        if (kcnt_q == 2'h0)
                        begin
                            wb0_q <= nvm_rdata;
                        end
                        if (kcnt_q == 2'h1)
                        begin
                            wb1_q <= nvm_rdata;
                        end
                        if (kcnt_q == `TWL_WIN_LAST_BYTE)
                        begin
                            found_q <= fin_found;
                            cand_q <= fin_idx;
                            wcnt_q <= wcnt_q + 5'h01;
                            if (wcnt_q == `TWL_LAST_SET)
                            begin
                                // Pointer moves only when some window matched
                                if (fin_found)
                                begin
                                    sel_q <= fin_idx;
                                    addr_q <= 11'(fin_idx) * 11'(`TWL_WS_BYTES);
                                    ccnt_q <= 7'h00;
                                    lst_q <= L_COPY;
                                end
                                else
                                begin
                                    lst_q <= L_IDLE;
                                    busy_q <= 1'b0;
                                end
                            end
                        end
                    end
                end
                L_COPY:
                begin
                    if (nvm_ack)
                    begin
                        addr_q <= addr_q + 11'h001;
                        ccnt_q <= ccnt_q + 7'h01;
                        if (ccnt_q == `TWL_LAST_WS_BYTE)
                        begin
                            lst_q <= L_IDLE;
                            busy_q <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    lst_q <= L_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Read request drops for a cycle after each ack so every byte is one handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_q <= 1'b0;
        end
        else if (nvm_ack)
        begin
            req_q <= 1'b0;
        end
        else if (lst_q == L_SCAN || lst_q == L_COPY)
        begin
            req_q <= 1'b1;
        end
    end

    // Two-stage synchronisers for the sensor lines
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
        end
        else
        begin
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
        end
    end

    // A sensor holding the clock low stretches the high phase
    assign stall = (ist_q == I_BIT) && (qph_q == 2'h2) && !scl_s_q;
    assign tick = (qcnt_q == 8'(`TWL_SCL_QUARTER_CYC - 1)) && !stall;
    assign addr_byte = {`TWL_SENSOR_ADDR, 1'b1};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            qcnt_q <= 8'h00;
        end
        else if (ist_q == I_IDLE || tick)
        begin
            qcnt_q <= 8'h00;
        end
        else if (!stall)
        begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    // Two-wire read: start, address+read, ack, byte, ack, byte, nack, stop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ist_q <= I_IDLE;
            qph_q <= 2'h0;
            bit_q <= 5'h00;
            sh_q <= 16'h0000;
            nack_q <= 1'b0;
            i2c_done_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
            temp_q <= `TWL_RST_TEMP;
        end
        else
        begin
            i2c_done_q <= 1'b0;
            case (ist_q)
                I_IDLE:
                begin
                    if (lst_q == L_IDLE && load_start)
                    begin
                        ist_q <= I_START;
                        qph_q <= 2'h0;
                        nack_q <= 1'b0;
                    end
                end
                I_START:
                begin
                    if (tick)
                    begin
                        qph_q <= qph_q + 2'h1;
                        if (qph_q == 2'h0)
                        begin
                            sda_oe_n_q <= 1'b0;
                        end
                        else
                        begin
                            scl_oe_n_q <= 1'b0;
                            ist_q <= I_BIT;
                            qph_q <= 2'h0;
                            bit_q <= 5'h00;
                        end
                    end
                end
                I_BIT:
                begin
                    if (tick)
                    begin
                        qph_q <= qph_q + 2'h1;
                        case (qph_q)
                            2'h0:
                            begin
                                if (bit_q <= `TWL_BIT_ADDR_LAST)
                                begin
                                    sda_oe_n_q <= addr_byte[3'(`TWL_BIT_ADDR_LAST - bit_q)];
                                end
                                else
                                begin
                                    sda_oe_n_q <= (bit_q != `TWL_BIT_MACK);
                                end
                            end
                            2'h1: scl_oe_n_q <= 1'b1;
                            2'h2:
                            begin
                                if (bit_q == `TWL_BIT_ACK && sda_s_q)
                                begin
                                    nack_q <= 1'b1;
                                end
                                if ((bit_q >= `TWL_BIT_B1_FIRST && bit_q <= `TWL_BIT_B1_LAST) ||
                                    (bit_q >= `TWL_BIT_B2_FIRST && bit_q <= `TWL_BIT_B2_LAST))
                                begin
                                    sh_q <= {sh_q[14:0], sda_s_q};
                                end
                            end
                            default:
                            begin
                                scl_oe_n_q <= 1'b0;
                                bit_q <= bit_q + 5'h01;
                                if (bit_q == `TWL_BIT_LAST)
                                begin
                                    ist_q <= I_STOP;
                                    qph_q <= 2'h0;
                                end
                            end
                        endcase
                    end
                end
                I_STOP:
                begin
                    if (tick)
                    begin
                        qph_q <= qph_q + 2'h1;
                        case (qph_q)
                            2'h0: sda_oe_n_q <= 1'b0;
                            2'h1: scl_oe_n_q <= 1'b1;
                            default:
                            begin
                                sda_oe_n_q <= 1'b1;
                                ist_q <= I_IDLE;
                                i2c_done_q <= 1'b1;
                                // A failed read keeps the last good temperature
                                if (!nack_q)
                                begin
                                    temp_q <= {sh_q[15:8], sh_q[7:4]};
                                end
                            end
                        endcase
                    end
                end
                default:
                begin
                    ist_q <= I_IDLE;
                    sda_oe_n_q <= 1'b1;
                    scl_oe_n_q <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ===== twl_loader_monitor.sv
// Port-level assertions for the waveform loader.
// Assumes it is bound to twl_loader and sees only its ports.
`timescale 1ns/1ps
`include "twl_defines.svh"
module twl_loader_monitor
    import twl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_is_data,
    input wire logic [7:0] cmd_byte,
    input wire logic load_start,
    input wire logic nvm_req,
    input wire logic [10:0] nvm_addr,
    input wire logic nvm_ack,
    input wire logic [7:0] nvm_rdata,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic [559:0] waveform_table_register,
    input wire twl_volt_t volt_setting,
    input wire logic [11:0] temperature,
    input wire logic [4:0] selection_pointer,
    input wire logic busy,
    input wire logic sensor_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_cmd_data(b);
        cmd_valid && !cmd_is_data && cmd_byte == b && !busy ##1 cmd_valid && cmd_is_data && !busy;
    endsequence
    // Scan to copy jumps, so the step from the last window byte is exempt
    sequence s_next;
        nvm_ack ##1 !nvm_req ##1 nvm_req;
    endsequence

    a_busy_rise: assert property (load_start && !busy |=> busy) else $error("busy missed");
    a_req_hold: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr)) else $error("req hold");
    a_ack_drop: assert property (nvm_ack |=> !nvm_req) else $error("req after ack");
    a_addr_step: assert property (s_next |-> nvm_addr == $past(nvm_addr, 2) + 11'd1
        || $past(nvm_addr, 2) == 11'd1974) else $error("address step");
    a_lines_idle: assert property (!busy |-> sda_oe_n && scl_oe_n) else $error("lines held");
    a_od_low: assert property (sda_out == 1'b0 && scl_out == 1'b0) else $error("open drain");
    a_req_idle: assert property (!busy |-> !nvm_req) else $error("idle req");
    a_table_hold: assert property (!busy && !cmd_valid |=> $stable(waveform_table_register)
        && $stable(volt_setting)) else $error("table moved");
    a_state_hold: assert property (!busy |=> $stable(temperature) && $stable(selection_pointer)
        && $stable(sensor_error)) else $error("state moved");
    a_host_gate: assert property (s_cmd_data(8'h03) |=> volt_setting.gate_level == $past(cmd_byte))
        else $error("gate byte");
    a_host_first: assert property (s_cmd_data(8'h32) |=> waveform_table_register[7:0] == $past(cmd_byte))
        else $error("first byte");
endmodule

bind twl_loader twl_loader_monitor u_mon (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte), .load_start(load_start), .nvm_req(nvm_req),
    .nvm_addr(nvm_addr), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .waveform_table_register(waveform_table_register), .volt_setting(volt_setting),
    .temperature(temperature), .selection_pointer(selection_pointer), .busy(busy), .sensor_error(sensor_error));

// ===== twl_sensor_model.sv
// Behavioural temperature sensor on the open-drain two-wire bus.
// Assumes resolved line levels with pull-ups; pull low means drive 0.
`timescale 1ns/1ps
`include "twl_defines.svh"
module twl_sensor_model
(
    input wire logic scl,
    input wire logic sda,
    input wire logic [15:0] word,
    input wire logic nack,
    output logic pull
);
    int f = 0;
    logic [7:0] sh = 8'h00;
    logic ok = 1'b0;
    initial pull = 1'b0;
    // Start condition restarts the bit count
    always @(negedge sda)
        if (scl)
            f = 0;
    always @(posedge scl)
        sh = {sh[6:0], sda};
    // Data changes only while the clock is low
    always @(negedge scl)
    begin
        f = f + 1;
        if (f == 9)
            ok = (sh == {`TWL_SENSOR_ADDR, 1'b1}) && !nack;
        pull = 1'b0;
        if (f == 9)
            pull = ok;
        else if (f >= 10 && f <= 17)
            pull = ok & ~word[25 - f];
        else if (f >= 19 && f <= 26)
            pull = ok & ~word[26 - f];
    end
endmodule

// ===== twl_loader_tb_top.sv
// Self-checking bench: host writes, temperature loads, sensor refusal.
// Assumes a behavioural store answering each request one cycle later.
`timescale 1ns/1ps
`include "twl_defines.svh"
module twl_loader_tb_top
    import twl_pkg::*;
;
    logic clk = 0, rst_n = 0, cmd_valid = 0, cmd_is_data = 0, load_start = 0, nvm_ack = 0, nack = 0;
    logic [7:0] cmd_byte = 8'h00, nvm_rdata = 8'h00;
    logic [15:0] word = 16'h0000;
    wire logic nvm_req, sda_out, sda_oe_n, scl_out, scl_oe_n, busy, sensor_error, pull;
    logic [10:0] nvm_addr;
    logic [559:0] tab, exp_tab;
    twl_volt_t volt;
    logic [47:0] exp_volt;
    logic [11:0] temp, exp_temp;
    logic [4:0] ptr, exp_ptr;
    logic [7:0] mem [0:1974];
    logic [8:0] hs [13] = '{9'h003, 9'h111, 9'h199, 9'h004, 9'h121, 9'h122, 9'h123,
        9'h03a, 9'h131, 9'h03b, 9'h141, 9'h077, 9'h1ff};
    int errors = 0, n_checks = 0, cyc = 0, i;
    wire sda = (sda_oe_n | sda_out) & ~pull;
    wire scl = scl_oe_n | scl_out;

    twl_loader dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_is_data(cmd_is_data),
        .cmd_byte(cmd_byte), .load_start(load_start), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
        .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .waveform_table_register(tab),
        .volt_setting(volt), .temperature(temp), .selection_pointer(ptr), .busy(busy),
        .sensor_error(sensor_error));
    twl_sensor_model sensor (.scl(scl), .sda(sda), .word(word), .nack(nack), .pull(pull));

    always #25 clk = ~clk;
    // Store answers one cycle after a request; outside an answer the data toggles
    always @(negedge clk)
    begin
        nvm_ack <= nvm_req && !nvm_ack;
        nvm_rdata <= (nvm_req && !nvm_ack) ? mem[nvm_addr] : ~nvm_rdata;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] sb(input int m, input int k);
        return 8'(m * 3 + k + 1);
    endfunction

    task check(input logic [559:0] got, input logic [559:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task send(input logic [8:0] v);
        cmd_valid = 1'b1;
        {cmd_is_data, cmd_byte} = v;
        @(negedge clk);
    endtask

    task set_win(input int w, input logic [11:0] lo, input logic [11:0] hi);
        mem[1900 + 3 * w] = lo[7:0];
        mem[1901 + 3 * w] = {hi[3:0], lo[11:8]};
        mem[1902 + 3 * w] = hi[11:4];
    endtask

    task clr_win;
        for (i = 1900; i < 1975; i++)
            mem[i] = 8'h00;
    endtask

    task t_host;
        send(9'h032);
        // The extra 71st byte is dropped
        for (i = 0; i < 71; i++)
            send({1'b1, 8'(i ^ 8'h5a)});
        for (i = 0; i < 13; i++)
            send(hs[i]);
        cmd_valid = 1'b0;
        @(negedge clk);
        for (i = 0; i < 70; i++)
            exp_tab[8 * i +: 8] = 8'(i ^ 8'h5a);
        exp_volt = 48'h112122233141;
        check(tab, exp_tab);
        check(volt, exp_volt);
        $display("test host done");
    endtask

    task t_load(input logic [11:0] t, input logic hit, input logic [4:0] m, input logic nk);
        word = {t, 4'h5};
        nack = nk;
        load_start = 1'b1;
        @(negedge clk);
        load_start = 1'b0;
        check(busy, 1'b1);
        for (i = 0; i < 12000 && busy !== 1'b0; i++)
            @(negedge clk);
        if (hit)
        begin
            for (i = 0; i < 70; i++)
                exp_tab[8 * i +: 8] = sb(m, i);
            for (i = 70; i < 76; i++)
                exp_volt[8 * (75 - i) +: 8] = sb(m, i);
            exp_ptr = m;
        end
        if (!nk)
            exp_temp = t;
        check(busy, 1'b0);
        check(sensor_error, nk);
        check(temp, exp_temp);
        check(ptr, exp_ptr);
        check(tab, exp_tab);
        check(volt, exp_volt);
        $display("test load %0h done", t);
    endtask

    initial
    begin
        for (i = 0; i < 1900; i++)
            mem[i] = sb(i / 76, i % 76);
        clr_win();
        exp_tab = '0;
        exp_volt = {`TWL_RST_GATE, `TWL_RST_VSH1, `TWL_RST_VSH2, `TWL_RST_VSL, `TWL_RST_DUMMY, `TWL_RST_WIDTH};
        exp_ptr = 5'd0;
        exp_temp = `TWL_RST_TEMP;
        repeat (2) @(negedge clk);
        check(tab, exp_tab);
        check(volt, exp_volt);
        check({temp, ptr, busy, sda_oe_n, scl_oe_n}, {exp_temp, exp_ptr, 3'b011});
        @(negedge clk);
        rst_n = 1'b1;
        t_host();
        // Overlapping, unsorted windows; a low limit equal to the reading does not match, a high limit equal to it does
        set_win(3, 12'h0f0, 12'h190);
        set_win(5, 12'h140, 12'h1e0);
        set_win(24, 12'h18f, 12'h190);
        set_win(1, 12'h190, 12'h7ff);
        t_load(12'h190, 1'b1, 5'd24, 1'b0);
        t_load(12'h800, 1'b0, 5'd0, 1'b0);
        clr_win();
        set_win(0, 12'h800, 12'h050);
        set_win(2, 12'he70, 12'h000);
        set_win(7, 12'h000, 12'h7ff);
        t_load(12'he70, 1'b1, 5'd0, 1'b0);
        t_load(12'h123, 1'b0, 5'd0, 1'b1);
        report_and_stop();
    end
endmodule
